// *** lds_cfg.svh ***
// constants for the lubricant dispense scheduler
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH
// ==========================================================================
// timing
`define LDS_CLK_NS 8
`define LDS_TICK_NS 1000000000
`define LDS_TICK_CYC (`LDS_TICK_NS / `LDS_CLK_NS)
`define LDS_STROKE_NS 100000000
`define LDS_STROKE_CYC (`LDS_STROKE_NS / `LDS_CLK_NS)
`define LDS_EXT_LIMIT_S 15
`define LDS_EXT_LIMIT_TICKS 4'd15
`define LDS_BLINK_S 5
// ==========================================================================
// schedule arithmetic, volumes in units of 0.01 ml
`define LDS_SEC_PER_HOUR 32'd3600
`define LDS_SEC_PER_MONTH 32'd2592000
`define LDS_STROKE_CML 32'd16
`define LDS_CART_SMALL_CML 16'd12500
`define LDS_CART_LARGE_CML 16'd25000
// ==========================================================================
// ranges and defaults
`define LDS_PAUSE_MIN 8'd1
`define LDS_PAUSE_MAX 8'd240
`define LDS_PAUSE_DEF 8'd6
`define LDS_CYC_MIN 4'd1
`define LDS_CYC_MAX 4'd10
`define LDS_CYC_DEF 4'd1
`define LDS_MONTH_MIN 5'd1
`define LDS_MONTH_MAX 5'd24
`define LDS_MONTH_DEF 5'd6
`define LDS_PRIME_STROKES 5'd10
`define LDS_LEFT_MAX 6'd31
`endif

// *** lds_pkg.sv ***
// types for the lubricant dispense scheduler
package lds_pkg;
  typedef enum logic [1:0] {LDS_MODE_INTERVAL, LDS_MODE_DRAIN, LDS_MODE_EXT} lds_mode_e;
  typedef enum logic {LDS_IDLE, LDS_STROKE} lds_stroke_e;
endpackage : lds_pkg

// *** lds_plc_model.sv ***
// controller model that drives the dispense command line
`timescale 1ns/10ps
module lds_plc_model (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire logic [3:0] count,
  input wire logic [15:0] hold,
  // command line and status
  output logic ext_cmd,
  output logic done
);
  // ==========================================================================
  // pulse generator
  // the line is actively driven low between pulses, as a controller output is;
  // the low gap is one clock longer than the high time so strokes never merge unless asked to
  initial begin
    ext_cmd = 1'b0;
    done = 1'b1;
    forever begin
      @(posedge go);
      done = 1'b0;
      repeat (count) begin
        @(negedge clk);
        ext_cmd = 1'b1;
        repeat (hold) @(negedge clk);
        ext_cmd = 1'b0;
        repeat (hold) @(negedge clk);
      end
      done = 1'b1;
    end
  end
endmodule : lds_plc_model

// *** lds_pulse_div.sv ***
// counts enable pulses and emits one tick every LIMIT of them
`timescale 1ns/10ps
module lds_pulse_div #(
  parameter int unsigned LIMIT = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic clr,
  input wire logic en,
  // result
  output logic tick
);
  localparam int W = (LIMIT > 2) ? $clog2(LIMIT) : 1;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;
  // ==========================================================================
  // next count; clear restarts the full period
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (clr) begin
      next_cnt = '0;
    end else if (en) begin
      if (cnt == W'(LIMIT - 1)) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end
  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : lds_pulse_div

// *** lds_scheduler.sv ***
// lubricant dispense scheduler: settings, stroke timing and stroke engine
`timescale 1ns/10ps
`include "lds_cfg.svh"
module lds_scheduler import lds_pkg::*; #(
  parameter int unsigned TICK_CYC = `LDS_TICK_CYC,
  parameter int unsigned STROKE_CYC = `LDS_STROKE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // on/off and settings menu
  input wire logic switch_on_req,
  input wire logic switch_off_req,
  input wire logic mode_wr,
  input wire logic [1:0] mode_sel,
  input wire logic cart_wr,
  input wire logic cart_large_in,
  input wire logic pause_wr,
  input wire logic [7:0] pause_in,
  input wire logic cycles_wr,
  input wire logic [3:0] cycles_in,
  input wire logic months_wr,
  input wire logic [4:0] months_in,
  // operator actions
  input wire logic manual_req,
  input wire logic prime_req,
  // controller command line
  input wire logic ext_cmd,
  // status
  output logic switched_on,
  output lds_mode_e op_mode,
  output logic cart_large,
  output logic [7:0] pause_hours,
  output logic [3:0] cycles_per_pause,
  output logic [4:0] drain_months,
  output logic setting_reject,
  output logic ext_fault,
  output logic ready_blink,
  // pump
  output logic stroke_drive,
  output logic busy
);
  // ==========================================================================
  // state
  logic ext_q, cycle_pend;
  logic [3:0] ext_sec;
  logic [31:0] acc;
  lds_stroke_e st;
  logic [4:0] strokes_left;
  logic [31:0] stroke_cnt;
  logic next_on, next_cart, next_reject, next_fault, next_ext_q, next_pend;
  lds_mode_e next_mode;
  logic [7:0] next_pause;
  logic [3:0] next_cycles, next_ext_sec;
  logic [4:0] next_months, next_left;
  logic [31:0] next_acc, next_stroke_cnt;
  lds_stroke_e next_st;
  logic next_drive, next_busy;
  // helpers
  logic sec_tick, sched_run, restart, fire, engine_idle, cycle_start;
  logic add_manual, add_ext, add_prime, any_add;
  logic [15:0] step;
  logic [31:0] thr;
  logic [32:0] acc_sum;
  logic [5:0] base;

  // ==========================================================================
  // one second time base, and the ready blink
  lds_pulse_div #(.LIMIT(TICK_CYC)) u_sec (
    .clk(clk), .rst_b(rst_b), .clr(1'b0), .en(1'b1), .tick(sec_tick)
  );
  lds_pulse_div #(.LIMIT(`LDS_BLINK_S)) u_blink (
    .clk(clk), .rst_b(rst_b), .clr(!switched_on || ext_fault),
    .en(sec_tick), .tick(ready_blink)
  );

  // ==========================================================================
  // schedule arithmetic: each second adds step, a start fires when the sum
  // reaches thr; the remainder is kept so spacing stays even without a divider
  always_comb begin
    if (op_mode == LDS_MODE_INTERVAL) begin
      step = {12'h000, cycles_per_pause};
      thr = 32'({24'h000000, pause_hours} * `LDS_SEC_PER_HOUR);
    end else begin
      step = cart_large ? `LDS_CART_LARGE_CML : `LDS_CART_SMALL_CML;
      thr = 32'({27'h0, drain_months} * `LDS_SEC_PER_MONTH * `LDS_STROKE_CML);
    end
  end
  assign acc_sum = {1'b0, acc} + {17'h0, step};
  assign sched_run = switched_on && (op_mode != LDS_MODE_EXT);
  assign fire = sched_run && sec_tick && (acc_sum >= {1'b0, thr});

  // ==========================================================================
  // settings, on/off, timers and fault detection
  always_comb begin
    next_on = switched_on;
    next_mode = op_mode;
    next_cart = cart_large;
    next_pause = pause_hours;
    next_cycles = cycles_per_pause;
    next_months = drain_months;
    next_reject = 1'b0;
    next_ext_q = ext_cmd;
    next_ext_sec = ext_sec;
    next_fault = ext_fault;
    next_pend = cycle_pend;
    restart = 1'b0;
    if (switch_on_req && !switched_on) begin
      next_on = 1'b1;
      restart = 1'b1;
    end else if (switch_off_req) begin
      next_on = 1'b0;
    end
    // mode and cartridge held while running
    if (mode_wr && !switched_on) begin
      if (mode_sel == 2'h3) begin
        next_reject = 1'b1;
      end else begin
        next_mode = lds_mode_e'(mode_sel);
        restart = 1'b1;
      end
    end
    if (cart_wr && !switched_on) begin
      next_cart = cart_large_in;
      restart = 1'b1;
    end
    if (pause_wr) begin
      if (pause_in < `LDS_PAUSE_MIN || pause_in > `LDS_PAUSE_MAX) begin
        next_reject = 1'b1;
      end else begin
        next_pause = pause_in;
        restart = 1'b1;
      end
    end
    if (cycles_wr) begin
      if (cycles_in < `LDS_CYC_MIN || cycles_in > `LDS_CYC_MAX) begin
        next_reject = 1'b1;
      end else begin
        next_cycles = cycles_in;
        restart = 1'b1;
      end
    end
    if (months_wr) begin
      if (months_in < `LDS_MONTH_MIN || months_in > `LDS_MONTH_MAX) begin
        next_reject = 1'b1;
      end else begin
        next_months = months_in;
        restart = 1'b1;
      end
    end
    // interval accumulator; a restart drops the partial interval
    if (restart || !sched_run) begin
      next_acc = '0;
    end else if (sec_tick) begin
      next_acc = fire ? 32'(acc_sum - {1'b0, thr}) : acc_sum[31:0];
    end else begin
      next_acc = acc;
    end
    // a start that arrives while busy is held, the set winning over the take
    if (!sched_run) begin
      next_pend = 1'b0;
    end else if (fire) begin
      next_pend = 1'b1;
    end else if (cycle_start) begin
      next_pend = 1'b0;
    end
    // held command watchdog in whole seconds; trips one tick past the full count
    if (!switched_on) begin
      next_ext_sec = '0;
      next_fault = 1'b0; // limitation: only switching off or a reset clears it
    end else if (!ext_cmd || op_mode != LDS_MODE_EXT) begin
      next_ext_sec = '0;
    end else if (sec_tick) begin
      if (ext_sec == `LDS_EXT_LIMIT_TICKS) begin
        next_fault = 1'b1;
      end else begin
        next_ext_sec = ext_sec + 4'h1;
      end
    end
  end

  // registers; reset brings the factory state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switched_on <= 1'b0;
      op_mode <= LDS_MODE_INTERVAL;
      cart_large <= 1'b0;
      pause_hours <= `LDS_PAUSE_DEF;
      cycles_per_pause <= `LDS_CYC_DEF;
      drain_months <= `LDS_MONTH_DEF;
      setting_reject <= 1'b0;
      ext_q <= 1'b0;
      ext_sec <= '0;
      ext_fault <= 1'b0;
      acc <= '0;
      cycle_pend <= 1'b0;
    end else begin
      switched_on <= next_on;
      op_mode <= next_mode;
      cart_large <= next_cart;
      pause_hours <= next_pause;
      cycles_per_pause <= next_cycles;
      drain_months <= next_months;
      setting_reject <= next_reject;
      ext_q <= next_ext_q;
      ext_sec <= next_ext_sec;
      ext_fault <= next_fault;
      acc <= next_acc;
      cycle_pend <= next_pend;
    end
  end

  // ==========================================================================
  // stroke requests
  assign engine_idle = (st == LDS_IDLE) && (strokes_left == 5'h00);
  assign add_manual = switched_on && manual_req;
  assign add_prime = switched_on && prime_req;
  assign add_ext = switched_on && (op_mode == LDS_MODE_EXT) && ext_cmd && !ext_q;
  assign any_add = add_manual || add_prime || add_ext;
  // a cycle is only loaded into an empty engine, never merged into a burst
  assign cycle_start = cycle_pend && engine_idle && !any_add && sched_run;

  // ==========================================================================
  // stroke engine: strokes run back to back while any are queued
  always_comb begin
    if (cycle_start) begin
      base = (op_mode == LDS_MODE_INTERVAL) ? {2'b00, cycles_per_pause} : 6'h01;
    end else begin
      base = {1'b0, strokes_left} + {5'h00, add_manual} + {5'h00, add_ext}
           + (add_prime ? {1'b0, `LDS_PRIME_STROKES} : 6'h00);
      if (base > `LDS_LEFT_MAX) begin
        base = `LDS_LEFT_MAX;
      end
    end
    if (!switched_on) begin
      base = 6'h00; // switching off drops the queue, the running stroke ends
    end
    next_st = st;
    next_left = base[4:0];
    next_stroke_cnt = stroke_cnt;
    case (st)
      LDS_IDLE: begin
        if (base != 6'h00) begin
          next_st = LDS_STROKE;
          next_left = 5'(base - 6'h01);
          next_stroke_cnt = '0;
        end
      end
      LDS_STROKE: begin
        if (stroke_cnt == 32'(STROKE_CYC - 1)) begin
          next_stroke_cnt = '0;
          if (base != 6'h00) begin
            next_left = 5'(base - 6'h01);
          end else begin
            next_st = LDS_IDLE;
          end
        end else begin
          next_stroke_cnt = stroke_cnt + 32'h1;
        end
      end
      default: begin
        next_st = LDS_IDLE;
      end
    endcase
    next_drive = (next_st == LDS_STROKE);
    next_busy = next_drive || (next_left != 5'h00);
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= LDS_IDLE;
      strokes_left <= '0;
      stroke_cnt <= '0;
      stroke_drive <= 1'b0;
      busy <= 1'b0;
    end else begin
      st <= next_st;
      strokes_left <= next_left;
      stroke_cnt <= next_stroke_cnt;
      stroke_drive <= next_drive;
      busy <= next_busy;
    end
  end

  // ==========================================================================
  // checks, all on the system clock and, except a_reset_state, quiet during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_stroke_end;
    st == LDS_STROKE && stroke_cnt == 32'(STROKE_CYC - 1);
  endsequence
  sequence s_new_stroke;
    st == LDS_STROKE && stroke_cnt == 32'h0;
  endsequence
  a_range_reject: assert property (pause_wr && (pause_in == 8'h00 || pause_in > `LDS_PAUSE_MAX)
    |=> setting_reject && pause_hours == $past(pause_hours)) else $error("bad pause accepted");
  a_even_step: assert property (sec_tick && sched_run && !restart && !fire
    |=> {1'b0, acc} == $past(acc_sum)) else $error("accumulator step wrong");
  a_back_to_back: assert property (s_stroke_end ##0 (strokes_left != 5'h00 && switched_on)
    |=> s_new_stroke) else $error("gap between strokes");
  a_cycle_load: assert property (cycle_start && op_mode == LDS_MODE_INTERVAL
    |=> stroke_drive && strokes_left == $past(cycles_per_pause) - 4'h1) else $error("cycle length wrong");
  a_auto_start: assert property (fire |=> cycle_pend) else $error("expiry did not start cycle");
  a_month_reject: assert property (months_wr && months_in > `LDS_MONTH_MAX
    |=> drain_months == $past(drain_months)) else $error("bad months accepted");
  a_drain_step: assert property (op_mode == LDS_MODE_DRAIN && cart_large
    |-> step == `LDS_CART_LARGE_CML) else $error("drain step wrong");
  a_mode_locked: assert property ((mode_wr || cart_wr) && switched_on
    |=> op_mode == $past(op_mode) && cart_large == $past(cart_large)) else $error("setting changed while on");
  a_reset_state: assert property (disable iff (1'b0) !rst_b |=> !switched_on
    && op_mode == LDS_MODE_INTERVAL && pause_hours == `LDS_PAUSE_DEF && cycles_per_pause == `LDS_CYC_DEF
    && drain_months == `LDS_MONTH_DEF) else $error("reset defaults wrong");
  a_off_quiet: assert property (!sched_run |-> !cycle_start ##1 acc == 32'h0 && !cycle_pend)
    else $error("schedule ran while off or external");
  a_prime_burst: assert property (engine_idle && add_prime && !add_manual && !add_ext
    |=> stroke_drive && strokes_left == `LDS_PRIME_STROKES - 5'h01) else $error("prime burst wrong");
  a_manual_one: assert property (engine_idle && add_manual && !add_prime && !add_ext
    |=> stroke_drive && strokes_left == 5'h00) else $error("manual stroke wrong");
  a_ext_fault: assert property (sec_tick && ext_cmd && switched_on && op_mode == LDS_MODE_EXT
    && ext_sec == `LDS_EXT_LIMIT_TICKS |=> ext_fault) else $error("held command not flagged");
  a_blink_gate: assert property (ready_blink |-> $past(switched_on) && !$past(ext_fault))
    else $error("blink while off or faulted");
  a_restart: assert property (restart |=> acc == 32'h0) else $error("timer not restarted");
  a_no_overlap: assert property (cycle_start |-> st == LDS_IDLE && strokes_left == 5'h00)
    else $error("cycle overlapped strokes");
endmodule : lds_scheduler

// *** testbench.sv ***
// self-checking bench for the lubricant dispense scheduler
`timescale 1ns/10ps
module testbench;
  import lds_pkg::*;
  // ==========================================================================
  // stimulus, design and controller model
  localparam int TICK = 20;
  localparam int SC = 4;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic switch_on_req = 1'b0, switch_off_req = 1'b0, manual_req = 1'b0, prime_req = 1'b0;
  logic mode_wr = 1'b0, cart_wr = 1'b0, pause_wr = 1'b0, cycles_wr = 1'b0, months_wr = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic cart_large_in = 1'b0;
  logic [7:0] pause_in = 8'h00;
  logic [3:0] cycles_in = 4'h0;
  logic [4:0] months_in = 5'h00;
  logic plc_go = 1'b0;
  logic [3:0] plc_count = 4'h0;
  logic [15:0] plc_hold = 16'h0000;
  logic ext_cmd, plc_done, switched_on, cart_large, setting_reject, ext_fault, ready_blink, stroke_drive, busy;
  lds_mode_e op_mode;
  logic [7:0] pause_hours;
  logic [3:0] cycles_per_pause;
  logic [4:0] drain_months;
  int bad_count = 0, checks = 0, cyc = 0, run = 0, seed = 15, ok, t0, gap;
  int exp_q[$], starts[$], blinks[$];
  // settings table: kind, value, whether it lands while switched off
  int tk[12] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3};
  int tv[12] = '{0, 241, 240, 0, 11, 10, 0, 25, 24, 3, 1, 0};
  int ta[12] = '{0, 0, 1, 0, 0, 1, 0, 0, 1, 0, 1, 1};

  // 8 ns clock
  always #4 clk = ~clk;

  lds_scheduler #(.TICK_CYC(TICK), .STROKE_CYC(SC)) i_dut (.clk(clk), .rst_b(rst_b),
    .switch_on_req(switch_on_req), .switch_off_req(switch_off_req), .mode_wr(mode_wr), .mode_sel(mode_sel),
    .cart_wr(cart_wr), .cart_large_in(cart_large_in), .pause_wr(pause_wr), .pause_in(pause_in),
    .cycles_wr(cycles_wr), .cycles_in(cycles_in), .months_wr(months_wr), .months_in(months_in),
    .manual_req(manual_req), .prime_req(prime_req), .ext_cmd(ext_cmd), .switched_on(switched_on),
    .op_mode(op_mode), .cart_large(cart_large), .pause_hours(pause_hours), .cycles_per_pause(cycles_per_pause),
    .drain_months(drain_months), .setting_reject(setting_reject), .ext_fault(ext_fault),
    .ready_blink(ready_blink), .stroke_drive(stroke_drive), .busy(busy));

  lds_plc_model i_plc (.clk(clk), .go(plc_go), .count(plc_count), .hold(plc_hold), .ext_cmd(ext_cmd),
    .done(plc_done));

  // ==========================================================================
  // comparison and closing
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] cur(input int k);
    case (k)
      0: cur = {24'h0, pause_hours};
      1: cur = {28'h0, cycles_per_pause};
      2: cur = {27'h0, drain_months};
      3: cur = {30'h0, op_mode};
      default: cur = {31'h0, cart_large};
    endcase
  endfunction : cur

  // ==========================================================================
  // drivers, all at the falling edge
  // one settings write; acc says whether it should land, rej whether it is refused
  task automatic setw(input int k, input int v, input logic acc, input logic rej);
    logic [31:0] old;
    old = cur(k);
    @(negedge clk);
    case (k)
      0: begin
        pause_wr = 1'b1;
        pause_in = v[7:0];
      end
      1: begin
        cycles_wr = 1'b1;
        cycles_in = v[3:0];
      end
      2: begin
        months_wr = 1'b1;
        months_in = v[4:0];
      end
      3: begin
        mode_wr = 1'b1;
        mode_sel = v[1:0];
      end
      default: begin
        cart_wr = 1'b1;
        cart_large_in = v[0];
      end
    endcase
    @(negedge clk);
    pause_wr = 1'b0;
    cycles_wr = 1'b0;
    months_wr = 1'b0;
    mode_wr = 1'b0;
    cart_wr = 1'b0;
    check("setting refused", {31'h0, rej}, {31'h0, setting_reject});
    check("setting value", acc ? v : old, cur(k));
  endtask : setw

  // one-cycle pulse: 0 on, 1 off, 2 manual stroke, 3 prime
  task automatic pulse(input int k);
    @(negedge clk);
    switch_on_req = (k == 0);
    switch_off_req = (k == 1);
    manual_req = (k == 2);
    prime_req = (k == 3);
    @(negedge clk);
    switch_on_req = 1'b0;
    switch_off_req = 1'b0;
    manual_req = 1'b0;
    prime_req = 1'b0;
  endtask : pulse

  task automatic plc(input int n, input int h);
    @(negedge clk);
    plc_count = n[3:0];
    plc_hold = h[15:0];
    plc_go = 1'b1; // raised last so the model reads a settled count and hold
    @(negedge clk);
    plc_go = 1'b0;
    repeat (2 * n * h + 8) if (plc_done !== 1'b1) @(negedge clk);
  endtask : plc

  // bounded wait for the stroke queue to drain
  task automatic wait_idle();
    repeat (200) if (busy !== 1'b0) @(negedge clk);
  endtask : wait_idle

  // ==========================================================================
  // monitor: each run of stroke_drive is settled against the oldest note;
  // sampled at the falling edge, where the registered outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (ready_blink === 1'b1) blinks.push_back(cyc);
    if (stroke_drive === 1'b1) begin
      if (run == 0) starts.push_back(cyc);
      run++;
    end else if (run != 0) begin
      check("burst cycles", exp_q.size() ? exp_q.pop_front() * SC : 0, run);
      run = 0;
    end
    if (cyc == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check("switched on", 32'h0, switched_on);
    check("mode", LDS_MODE_INTERVAL, op_mode);
    check("pause", 32'h6, pause_hours);
    check("cycles", 32'h1, cycles_per_pause);
    check("months", 32'h6, drain_months);
    // a manual request while off must not move the pump
    pulse(2);
    repeat (10) @(negedge clk);
    check("busy while off", 32'h0, busy);
    for (int i = 0; i < 12; i++) setw(tk[i], tv[i], ta[i] != 0, ta[i] == 0);
    setw(0, 1 + ($unsigned($random(seed)) % 240), 1'b1, 1'b0);
    setw(4, 1, 1'b1, 1'b0);
    setw(4, 0, 1'b1, 1'b0);
    // mode and cartridge are frozen once switched on
    pulse(0);
    check("switched on", 32'h1, switched_on);
    setw(3, 1, 1'b0, 1'b0);
    setw(4, 1, 1'b0, 1'b0);
    exp_q.push_back(1);
    pulse(2);
    wait_idle();
    exp_q.push_back(10);
    pulse(3);
    wait_idle();
    // interval mode, 1 h over 10 cycles of 10 strokes; a manual stroke joins the first cycle
    exp_q.push_back(11);
    exp_q.push_back(10);
    ok = starts.size();
    setw(0, 1, 1'b1, 1'b0);
    t0 = cyc;
    repeat (8000) if (starts.size() == ok) @(negedge clk);
    pulse(2);
    repeat (8000) if (starts.size() < ok + 2) @(negedge clk);
    gap = starts[ok + 1] - starts[ok];
    check("cycle spacing", 32'h1, gap >= 359 * TICK && gap <= 361 * TICK);
    check("first cycle delay", 32'h1, starts[ok] - t0 >= 358 * TICK && starts[ok] - t0 <= 362 * TICK);
    check("blink gap", 5 * TICK, blinks[$] - blinks[$ - 1]);
    wait_idle();
    // drain mode, one month, large cartridge
    pulse(1);
    setw(3, 1, 1'b1, 1'b0);
    setw(4, 1, 1'b1, 1'b0);
    setw(2, 1, 1'b1, 1'b0);
    exp_q.push_back(1);
    ok = starts.size();
    pulse(0);
    t0 = cyc;
    repeat (34000) if (starts.size() == ok) @(negedge clk);
    gap = (2592000 * 16 + 24999) / 25000;
    check("drain spacing", 32'h1, starts.size() > ok && starts[ok] - t0 >= (gap - 1) * TICK
      && starts[ok] - t0 <= (gap + 1) * TICK);
    wait_idle();
    // external mode: strokes follow the controller; a held line raises the fault
    pulse(1);
    setw(3, 2, 1'b1, 1'b0);
    pulse(0);
    repeat (5) exp_q.push_back(1);
    plc(3, 3 * SC);
    plc(1, 13 * TICK);
    check("fault on short hold", 32'h0, ext_fault);
    plc(1, 17 * TICK);
    check("fault on long hold", 32'h1, ext_fault);
    pulse(1);
    // the fault drops one edge after the run state does
    @(negedge clk);
    check("fault after off", 32'h0, ext_fault);
    repeat (10) @(negedge clk);
    check("notes left", 32'h0, exp_q.size());
    print_verdict();
  end
endmodule : testbench
